/* src/ifeb_top.sv */
// ----------------------------------------------------------------------------
// ifeb_top: interrupt flag and enable bank with request to the core
// ----------------------------------------------------------------------------
// assumes causes and register port run on clk; levels come from outside
//
// Operation
// - an internal peripheral cause sets its flag among bits 15 to 8.
// - writing one clears a pulse flag; writing zero does nothing.
// - request only an enabled pending cause without a stronger rival.
// - flags set on every cause regardless of enable or level.
// - core acceptance never clears a flag; it requests again.
// - bits 7 to 0 show external status; writes are ignored.
// - pulse flags: 8-bit timer bit 8 up to I2C at bit 15.
// - level flags: port group 0 at bit 0 up to PWM at bit 7.
// - enable register at 0x4302, one enable per flag position.
// - after reset all flags and enables read zero.
// - pulse mode samples each edge, sets, then waits until cleared.
// - level mode samples every edge, flag follows the source.
// - no request unless controller enable bit 0 is one.
// - among pending causes the highest level, 0 to 7, goes forward.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ifeb_top
    import ifeb_pkg::*;
#(
    parameter int NSRC = IFEB_NSRC
) (
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [IFEB_ADDR_W-1:0] reg_addr,
    input wire logic [IFEB_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output var logic [IFEB_DATA_W-1:0] reg_rdata,
    // causes from the peripherals, bit order as the flags
    input wire logic [NSRC-1:0] cause_in,
    // configured level of each source, three bits each
    input wire logic [NSRC*IFEB_NLVL_W-1:0] src_levels,
    // request to the core
    output var ifeb_req_type core_req,
    // bank interrupt
    output var logic bank_irq
);

    // ------------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------------
    logic hit_flags, hit_en, hit_ctrl, hit_evt_clr, hit_evt_en;
    logic [NSRC-1:0] flag_clr;
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] lost_vec;

    // address decode for writes
    always_comb begin
        hit_flags = 1'b0;
        hit_en = 1'b0;
        hit_ctrl = 1'b0;
        hit_evt_clr = 1'b0;
        hit_evt_en = 1'b0;
        if (reg_addr == IFEB_OFS_FLAGS) begin
            hit_flags = reg_wr;
        end else if (reg_addr == IFEB_OFS_ENABLES) begin
            hit_en = reg_wr;
        end else if (reg_addr == IFEB_OFS_CONTROL) begin
            hit_ctrl = reg_wr;
        end else if (reg_addr == IFEB_OFS_EVT_CLEAR) begin
            hit_evt_clr = reg_wr;
        end else if (reg_addr == IFEB_OFS_EVT_ENABLE) begin
            hit_evt_en = reg_wr;
        end
    end

    assign flag_clr = ifeb_w1_mask(hit_flags, reg_wdata, IFEB_PULSE_MASK);

    // ------------------------------------------------------------------------
    // flag cells
    // ------------------------------------------------------------------------
    // internal causes at top byte
    generate
        for (genvar g = 0; g < NSRC; g++) begin : g_flag
            ifeb_flag_cell #(
                .PULSE(g >= IFEB_PULSE_LO)
            ) u_cell (
                .clk(clk),
                .sys_rst(sys_rst),
                .cause(cause_in[g]),
                .clear(flag_clr[g]),
                .flag_q(flags[g]),
                .lost(lost_vec[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // enables, control and event registers
    // ------------------------------------------------------------------------
    logic [NSRC-1:0] en_q, en_d;
    logic ctrl_en_q, ctrl_en_d;
    logic [IFEB_EVT_W-1:0] evt_q, evt_d, evt_en_q, evt_en_d;
    logic [IFEB_EVT_W-1:0] evt_set, evt_clr;
    ifeb_req_type req_d;

    // next values of the software registers
    always_comb begin
        en_d = hit_en ? reg_wdata : en_q;
        ctrl_en_d = hit_ctrl ? reg_wdata[IFEB_CTRL_EN_BIT] : ctrl_en_q;
        evt_en_d = hit_evt_en ? reg_wdata[IFEB_EVT_W-1:0] : evt_en_q;
        evt_clr = hit_evt_clr ? reg_wdata[IFEB_EVT_W-1:0] : '0;
        evt_set = '0;
        evt_set[IFEB_EVT_REQ_BIT] = req_d.valid & ~core_req.valid;
        evt_set[IFEB_EVT_LOST_BIT] = |lost_vec;
        // a new event wins over a clear in the same cycle
        evt_d = (evt_q & ~evt_clr) | evt_set;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= IFEB_RST_ENABLES;
            ctrl_en_q <= IFEB_RST_CTRL_EN;
            evt_q <= IFEB_RST_EVT;
            evt_en_q <= IFEB_RST_EVT;
        end else begin
            en_q <= en_d;
            ctrl_en_q <= ctrl_en_d;
            evt_q <= evt_d;
            evt_en_q <= evt_en_d;
        end
    end

    // ------------------------------------------------------------------------
    // arbitration and request to the core
    // ------------------------------------------------------------------------
    logic arb_hit;
    logic [IFEB_IDX_W-1:0] arb_idx;
    logic [IFEB_NLVL_W-1:0] arb_lvl;
    logic irq_d;

    ifeb_prio_arb #(
        .NSRC(NSRC)
    ) u_arb (
        .pend(flags & en_q),
        .levels(src_levels),
        .hit(arb_hit),
        .win_idx(arb_idx),
        .win_lvl(arb_lvl)
    );

    // request word; flags stay set after acceptance, so it simply persists
    always_comb begin
        req_d = IFEB_REQ_IDLE;
        if (ctrl_en_q && arb_hit) begin
            req_d.valid = 1'b1;
            req_d.level = arb_lvl;
            req_d.index = arb_idx;
        end
        irq_d = |(evt_d & evt_en_d);
    end

    // registered request word and bank interrupt
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_req <= IFEB_REQ_IDLE;
            bank_irq <= 1'b0;
        end else begin
            core_req <= req_d;
            bank_irq <= irq_d;
        end
    end

    // ------------------------------------------------------------------------
    // read data, valid in the cycle after the read strobe only
    // ------------------------------------------------------------------------
    logic [IFEB_DATA_W-1:0] rdata_d;

    // read mux, zero when no read strobe stands
    always_comb begin
        rdata_d = '0;
        if (!reg_rd) begin
            rdata_d = '0;
        end else if (reg_addr == IFEB_OFS_FLAGS) begin
            rdata_d = flags;
        end else if (reg_addr == IFEB_OFS_ENABLES) begin
            rdata_d = en_q;
        end else if (reg_addr == IFEB_OFS_CONTROL) begin
            rdata_d[IFEB_CTRL_EN_BIT] = ctrl_en_q;
        end else if (reg_addr == IFEB_OFS_EVT_STATUS) begin
            rdata_d[IFEB_EVT_W-1:0] = evt_q;
        end else if (reg_addr == IFEB_OFS_EVT_ENABLE) begin
            rdata_d[IFEB_EVT_W-1:0] = evt_en_q;
        end
    end

    // read data register, one cycle per strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    // helper: a pending enabled source whose level beats the forwarded one
    logic rival_above;

    always_comb begin
        rival_above = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (flags[i] && en_q[i] &&
                src_levels[i*IFEB_NLVL_W +: IFEB_NLVL_W] > req_d.level) begin
                rival_above = 1'b1;
            end
        end
    end

    pulse_flag_set_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        cause_in[IFEB_PULSE_LO] |=> flags[IFEB_PULSE_LO])
        else $error("pulse cause did not set its flag");

    w1c_clear_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        flag_clr[IFEB_SRC_I2C] && !cause_in[IFEB_SRC_I2C]
        |=> !flags[IFEB_SRC_I2C])
        else $error("write one did not clear pulse flag");

    w0_keep_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        flags[IFEB_SRC_UART] && !flag_clr[IFEB_SRC_UART]
        |=> flags[IFEB_SRC_UART])
        else $error("pulse flag dropped without a clear");

    level_follow_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        ##1 flags[IFEB_SRC_PORT0] == $past(cause_in[IFEB_SRC_PORT0]))
        else $error("level flag does not follow its cause");

    // level flags ignore writes of one
    level_nowrite_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        hit_flags && reg_wdata[IFEB_SRC_PORT0] && cause_in[IFEB_SRC_PORT0]
        |=> flags[IFEB_SRC_PORT0])
        else $error("write changed a level flag");

    ctrl_gate_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !ctrl_en_q |=> !core_req.valid)
        else $error("request raised while controller disabled");

    req_enabled_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        core_req.valid
        |-> |($past(flags & en_q) & (NSRC'(1) << core_req.index)))
        else $error("request for a disabled or idle cause");

    req_hold_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        core_req.valid && $stable(flags) && $stable(en_q)
        && $stable(ctrl_en_q) && $stable(src_levels) |=> core_req.valid)
        else $error("request dropped with the cause still pending");

    // no pending rival above the winner
    level_max_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        req_d.valid |-> !rival_above)
        else $error("request level below a pending rival");

    reset_zero_a: assert property (
        @(posedge clk)
        $fell(sys_rst) |-> flags == '0 && en_q == '0 && !core_req.valid)
        else $error("flags or enables not zero after reset");

    // dropped pulse leaves a sticky event
    lost_sticky_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (|lost_vec) |=> evt_q[IFEB_EVT_LOST_BIT])
        else $error("dropped pulse not recorded");

    enable_write_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        hit_en |=> en_q == $past(reg_wdata))
        else $error("enable register did not take the write");

    enable_read_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == IFEB_OFS_ENABLES |=> reg_rdata == $past(en_q))
        else $error("enable read returned a wrong word");

    // main scenarios
    cov_req: cover property (@(posedge clk) disable iff (sys_rst)
        !core_req.valid ##1 core_req.valid);
    cov_w1c: cover property (@(posedge clk) disable iff (sys_rst)
        flags[IFEB_SRC_SPI] ##1 flag_clr[IFEB_SRC_SPI]
        ##1 !flags[IFEB_SRC_SPI]);
    cov_two: cover property (@(posedge clk) disable iff (sys_rst)
        $countones(flags & en_q) > 1 && core_req.valid);
    cov_irq: cover property (@(posedge clk) disable iff (sys_rst) bank_irq);

endmodule
`default_nettype wire

/* src/ifeb_pkg.sv */
// ----------------------------------------------------------------------------
// ifeb_pkg: constants and types for the interrupt flag and enable bank
// ----------------------------------------------------------------------------
// assumes a 16-bit register port with byte addresses as printed
package ifeb_pkg;

    // geometry
    localparam int IFEB_NSRC = 16;
    localparam int IFEB_NLVL_W = 3;
    localparam int IFEB_IDX_W = 4;
    localparam int IFEB_DATA_W = 16;
    localparam int IFEB_ADDR_W = 16;

    // register offsets
    localparam logic [15:0] IFEB_OFS_FLAGS = 16'h4300;
    localparam logic [15:0] IFEB_OFS_ENABLES = 16'h4302;
    localparam logic [15:0] IFEB_OFS_CONTROL = 16'h4304;
    localparam logic [15:0] IFEB_OFS_EVT_STATUS = 16'h4320;
    localparam logic [15:0] IFEB_OFS_EVT_CLEAR = 16'h4322;
    localparam logic [15:0] IFEB_OFS_EVT_ENABLE = 16'h4324;

    // reset values
    localparam logic [15:0] IFEB_RST_FLAGS = 16'h0000;
    localparam logic [15:0] IFEB_RST_ENABLES = 16'h0000;
    localparam logic IFEB_RST_CTRL_EN = 1'h0;
    localparam logic [1:0] IFEB_RST_EVT = 2'h0;

    // field positions
    localparam int IFEB_CTRL_EN_BIT = 0;
    localparam int IFEB_LEVEL_LO = 0;  // level-following flags 7..0
    localparam int IFEB_PULSE_LO = 8;  // pulse-captured flags 15..8
    localparam logic [15:0] IFEB_PULSE_MASK = 16'hff00;
    localparam int IFEB_EVT_REQ_BIT = 0;  // a request was raised
    localparam int IFEB_EVT_LOST_BIT = 1;  // pulse seen while flag already set
    localparam int IFEB_EVT_W = 2;

    // source positions in the flag and enable registers
    localparam int IFEB_SRC_PORT0 = 0;
    localparam int IFEB_SRC_PORT1 = 1;
    localparam int IFEB_SRC_STOPWATCH = 2;
    localparam int IFEB_SRC_CLOCK_TMR = 3;
    localparam int IFEB_SRC_LF_TMR = 4;
    localparam int IFEB_SRC_SUPPLY_DET = 5;
    localparam int IFEB_SRC_DISPLAY = 6;
    localparam int IFEB_SRC_PWM_CAP = 7;
    localparam int IFEB_SRC_TMR8 = 8;
    localparam int IFEB_SRC_TMR16_0 = 9;
    localparam int IFEB_SRC_TMR16_1 = 10;
    localparam int IFEB_SRC_TMR16_2 = 11;
    localparam int IFEB_SRC_UART = 12;
    localparam int IFEB_SRC_REMOTE = 13;
    localparam int IFEB_SRC_SPI = 14;
    localparam int IFEB_SRC_I2C = 15;

    // request carried to the core
    typedef struct packed {
        logic valid;
        logic [IFEB_NLVL_W-1:0] level;
        logic [IFEB_IDX_W-1:0] index;
    } ifeb_req_type;

    localparam ifeb_req_type IFEB_REQ_IDLE = '{1'b0, 3'h0, 4'h0};

    // write-one decode: bits to act on when a register is written
    function automatic logic [15:0] ifeb_w1_mask(input logic hit,
                                                 input logic [15:0] data,
                                                 input logic [15:0] keep);
        ifeb_w1_mask = hit ? (data & keep) : 16'h0000;
    endfunction

endpackage

/* src/ifeb_flag_cell.sv */
// ----------------------------------------------------------------------------
// ifeb_flag_cell: one interrupt flag, pulse-captured or level-following
// ----------------------------------------------------------------------------
// assumes the cause comes from logic on the same system clock
`timescale 1ns/10ps
`default_nettype none
module ifeb_flag_cell
    import ifeb_pkg::*;
#(
    parameter bit PULSE = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cause,
    input wire logic clear,
    output var logic flag_q,
    output var logic lost
);

    logic flag_d;

    // next flag value; a cause in the clear cycle wins over the clear
    always_comb begin
        flag_d = flag_q;
        lost = 1'b0;
        if (PULSE) begin
            if (!flag_q) begin
                flag_d = cause;
            end else if (clear) begin
                flag_d = cause;
            end else begin
                lost = cause;
            end
        end else begin
            flag_d = cause;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q <= IFEB_RST_FLAGS[0];
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule
`default_nettype wire

/* src/ifeb_prio_arb.sv */
// ----------------------------------------------------------------------------
// ifeb_prio_arb: picks the pending cause of highest configured level
// ----------------------------------------------------------------------------
// assumes levels come from the level setup registers outside this bank
`timescale 1ns/10ps
`default_nettype none
module ifeb_prio_arb
    import ifeb_pkg::*;
#(
    parameter int NSRC = IFEB_NSRC
) (
    input wire logic [NSRC-1:0] pend,
    input wire logic [NSRC*IFEB_NLVL_W-1:0] levels,
    output var logic hit,
    output var logic [IFEB_IDX_W-1:0] win_idx,
    output var logic [IFEB_NLVL_W-1:0] win_lvl
);

    logic [IFEB_NLVL_W-1:0] lvl;

    // scan from the top index down so the lowest index wins a tie
    always_comb begin
        hit = 1'b0;
        win_idx = '0;
        win_lvl = '0;
        lvl = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            lvl = levels[i*IFEB_NLVL_W +: IFEB_NLVL_W];
            if (pend[i] && (!hit || lvl >= win_lvl)) begin
                hit = 1'b1;
                win_idx = IFEB_IDX_W'(i);
                win_lvl = lvl;
            end
        end
    end

endmodule
`default_nettype wire

/* test/ifeb_core_model.sv */
// ----------------------------------------------------------------------------
// ifeb_core_model: processor core taking leveled interrupt requests
// ----------------------------------------------------------------------------
// assumes core_req is registered on clk; core_ret stands for a handler return
`timescale 1ns/10ps
`default_nettype none
module ifeb_core_model
    import ifeb_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire ifeb_req_type core_req,
    input wire logic core_ret,
    output var logic core_ie_q,
    output var logic [7:0] acc_cnt_q
);
    logic [IFEB_NLVL_W-1:0] il_q;

    // samples the request every cycle, as a real core does
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_ie_q <= 1'b1;
            il_q <= 3'h0;
            acc_cnt_q <= 8'h00;
        end else if (core_req.valid && core_ie_q && core_req.level > il_q) begin
            core_ie_q <= 1'b0; // further requests masked
            il_q <= core_req.level;
            acc_cnt_q <= acc_cnt_q + 8'h01;
        end else if (core_ret) begin
            core_ie_q <= 1'b1;
            il_q <= 3'h0; // level cleared to zero
        end
    end
endmodule
`default_nettype wire

/* test/tb.sv */
// ----------------------------------------------------------------------------
// tb: self-checking bench for the interrupt flag and enable bank
// ----------------------------------------------------------------------------
// assumes one 40 MHz clock; source i is configured to level i mod 8
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin \
    n_compared++; \
    if ((a) !== (e)) begin \
        error_cnt++; \
        $display("wrong value %s expected %h seen %h", nm, e, a); \
    end \
end
module tb
    import ifeb_pkg::*;
;
    typedef struct {
        logic [15:0] c;
        logic [15:0] en;
        logic [15:0] f;
        ifeb_req_type r;
    } ifeb_row_type;

    logic clk, sys_rst, reg_wr, reg_rd, bank_irq, core_ret, core_ie_q;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, cause_in;
    logic [47:0] src_levels;
    logic [7:0] acc_cnt_q;
    ifeb_req_type core_req;
    int error_cnt = 0;
    int n_compared = 0;
    ifeb_row_type rows [6] = '{
        '{16'h0100, 16'hffff, 16'h0100, '{1'b1, 3'h0, 4'h8}},
        '{16'h0001, 16'hffff, 16'h0001, '{1'b1, 3'h0, 4'h0}},
        '{16'h8080, 16'hffff, 16'h8080, '{1'b1, 3'h7, 4'h7}},
        '{16'h4020, 16'hffff, 16'h4020, '{1'b1, 3'h6, 4'he}},
        '{16'h8000, 16'h7fff, 16'h8000, '{1'b0, 3'h0, 4'h0}},
        '{16'h0c00, 16'hffff, 16'h0c00, '{1'b1, 3'h3, 4'hb}}};

    ifeb_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cause_in(cause_in), .src_levels(src_levels),
        .core_req(core_req), .bank_irq(bank_irq));
    ifeb_core_model core_u (.clk(clk), .sys_rst(sys_rst), .core_req(core_req),
        .core_ret(core_ret), .core_ie_q(core_ie_q), .acc_cnt_q(acc_cnt_q));

    // ------------------------------------------------------------------------
    // clock, watchdog and verdict
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    // ------------------------------------------------------------------------
    // register port and stimulus tasks
    // ------------------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [15:0] a, input logic [15:0] e,
                         input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata)
    endtask

    task automatic pulse(input logic [15:0] c);
        @(posedge clk);
        cause_in <= c;
        @(posedge clk);
        cause_in <= 16'h0000;
    endtask

    task automatic ret_and_wait();
        @(posedge clk);
        core_ret <= 1'b1;
        @(posedge clk);
        core_ret <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // held causes, then cleared at the source and by writing ones
    task automatic run_row(input ifeb_row_type w);
        wr(IFEB_OFS_ENABLES, w.en);
        @(posedge clk);
        cause_in <= w.c;
        repeat (4) @(posedge clk);
        #1;
        `CHK("core_req", w.r, core_req)
        rdchk(IFEB_OFS_FLAGS, w.f, "flags");
        @(posedge clk);
        cause_in <= 16'h0000; // level source cleared at its origin
        wr(IFEB_OFS_FLAGS, 16'hffff);
        rdchk(IFEB_OFS_FLAGS, 16'h0000, "flags cleared");
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cause_in = 16'h0000;
        core_ret = 1'b0;
        for (int i = 0; i < 16; i++) begin
            src_levels[3*i +: 3] = 3'(i % 8);
        end
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK("core_req", IFEB_REQ_IDLE, core_req)
        rdchk(IFEB_OFS_FLAGS, 16'h0000, "flags");
        rdchk(IFEB_OFS_ENABLES, 16'h0000, "enables");
        rdchk(16'h4340, 16'h0000, "unmapped");
        wr(IFEB_OFS_ENABLES, 16'ha5c3);
        rdchk(IFEB_OFS_ENABLES, 16'ha5c3, "enables");
        // core acceptance with controller off, then on
        wr(IFEB_OFS_ENABLES, 16'h0200);
        pulse(16'h0200);
        repeat (4) @(posedge clk);
        #1;
        `CHK("valid off", 1'b0, core_req.valid)
        rdchk(IFEB_OFS_FLAGS, 16'h0200, "flags");
        wr(IFEB_OFS_CONTROL, 16'h0001);
        repeat (4) @(posedge clk);
        #1;
        `CHK("accepts", 8'h01, acc_cnt_q)
        `CHK("core_req", 8'h99, 8'(core_req))
        rdchk(IFEB_OFS_FLAGS, 16'h0200, "flags kept");
        ret_and_wait();
        `CHK("accepts again", 8'h02, acc_cnt_q)
        wr(IFEB_OFS_FLAGS, 16'h0200);
        ret_and_wait();
        `CHK("no retake", 8'h02, acc_cnt_q)
        rdchk(IFEB_OFS_CONTROL, 16'h0001, "control");
        // ordinary cases: every source alone, then the table
        for (int i = 0; i < 16; i++) begin
            run_row('{16'h0001 << i, 16'hffff, 16'h0001 << i,
                      '{1'b1, 3'(i % 8), 4'(i)}});
        end
        foreach (rows[k]) begin
            run_row(rows[k]);
        end
        // level flags ignore software writes
        @(posedge clk);
        cause_in <= 16'h0001;
        wr(IFEB_OFS_FLAGS, 16'h00ff);
        rdchk(IFEB_OFS_FLAGS, 16'h0001, "level flag");
        @(posedge clk);
        cause_in <= 16'h0000;
        rdchk(IFEB_OFS_FLAGS, 16'h0000, "level low");
        // pulse capture, write zero, lost pulse and bank interrupt
        wr(IFEB_OFS_ENABLES, 16'hffff);
        wr(IFEB_OFS_EVT_CLEAR, 16'h0003);
        wr(IFEB_OFS_EVT_ENABLE, 16'h0001);
        pulse(16'h0100);
        repeat (3) @(posedge clk);
        #1;
        `CHK("bank_irq", 1'b1, bank_irq)
        wr(IFEB_OFS_FLAGS, 16'h0000);
        rdchk(IFEB_OFS_FLAGS, 16'h0100, "write zero");
        pulse(16'h0100);
        rdchk(IFEB_OFS_EVT_STATUS, 16'h0003, "lost pulse");
        @(posedge clk);
        reg_addr <= IFEB_OFS_FLAGS;
        reg_wdata <= 16'h0100;
        reg_wr <= 1'b1;
        cause_in <= 16'h0100;
        @(posedge clk);
        reg_wr <= 1'b0;
        cause_in <= 16'h0000;
        rdchk(IFEB_OFS_FLAGS, 16'h0100, "set wins");
        wr(IFEB_OFS_FLAGS, 16'h0100);
        rdchk(IFEB_OFS_FLAGS, 16'h0000, "cleared");
        wr(IFEB_OFS_EVT_ENABLE, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq masked", 1'b0, bank_irq)
        wr(IFEB_OFS_EVT_CLEAR, 16'h0003);
        rdchk(IFEB_OFS_EVT_STATUS, 16'h0000, "events cleared");
        // reset in mid-run with a request standing
        pulse(16'h0100);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK("core_req", IFEB_REQ_IDLE, core_req)
        rdchk(IFEB_OFS_FLAGS, 16'h0000, "flags");
        rdchk(IFEB_OFS_ENABLES, 16'h0000, "enables");
        rdchk(IFEB_OFS_CONTROL, 16'h0000, "control");
        report_and_stop();
    end
endmodule
`default_nettype wire
